// ==== common/moc_params.svh ====
// Constants for the mode option configuration block
`ifndef MOC_PARAMS_SVH
`define MOC_PARAMS_SVH
// Avalon word offsets (byte address = 4 * index)
`define MOC_IDX_MODE_SEL 4'h0
`define MOC_IDX_MEM_IRQ 4'h1
`define MOC_IDX_PULLUP 4'h2
`define MOC_IDX_WDG_EN 4'h3
`define MOC_IDX_STATUS 4'h4
`define MOC_IDX_IRQ_REQ 4'h5
`define MOC_IDX_VECTOR 4'h6
`define MOC_IDX_MAP_CHECK 4'h7
// Printed addresses of the option registers
`define MOC_ADDR_MODE_SEL 16'h3FF1
`define MOC_ADDR_MEM_IRQ_FULL 16'h3FDF
`define MOC_ADDR_MEM_IRQ_LEG 16'h1FDF
`define MOC_ADDR_PULLUP_FULL 16'h3FF0
`define MOC_ADDR_PULLUP_LEG 16'h1FF0
`define MOC_ADDR_WDG_EN_LEG 16'h1FF1
// Mode select option fields
`define MOC_MS_SECURITY 7
`define MOC_MS_LEGACY 6
`define MOC_MS_RWDG 3
`define MOC_MS_STOPDIS 2
`define MOC_MS_RIRQ 1
`define MOC_MS_REDUCED 0
// Memory and interrupt option fields
`define MOC_MI_LOW_RAM 7
`define MOC_MI_PAGE_RAM 6
`define MOC_MI_SEC 3
`define MOC_MI_IRQ 1
`define MOC_WDG_EN_BIT 0
`define MOC_WDG_CLR_BIT 0
// Address ranges
`define MOC_RED_LO 16'h0100
`define MOC_RED_HI 16'h0FFF
`define MOC_LEG_LO 16'h2000
`define MOC_LEG_HI 16'h3FFF
`define MOC_LRAM_LO 16'h0030
`define MOC_LRAM_HI 16'h005F
`define MOC_LRES_LO 16'h0020
`define MOC_LRES_HI 16'h002F
`define MOC_PRAM_LO 16'h0100
`define MOC_PRAM_BYTES 16'h0060
// Vectors
`define MOC_VEC_RESET 16'h3FFE
`define MOC_VEC_SWI 16'h3FFC
`define MOC_VEC_EXT 16'h3FFA
`define MOC_VEC_TIMER 16'h3FF8
`define MOC_VEC_SCI 16'h3FF6
`define MOC_VEC_SPI 16'h3FF4
`define MOC_VEC_LEG_MASK 16'h1FFF
// Reset values
`define MOC_RST_BYTE 8'h00
// Fixed watchdog: 2**18 clocks
`define MOC_WDG_CYCLES 262144
`endif

// ==== common/moc_pkg.sv ====
// Types shared by the mode option configuration block
package moc_pkg;
   typedef enum logic [2:0] {
      MOC_FULL = 3'b001,
      MOC_REDUCED = 3'b010,
      MOC_LEGACY = 3'b100
   } moc_mode_t;
   typedef struct packed {
      logic reset_req;
      logic swi_req;
      logic ext_req;
      logic timer_req;
      logic sci_req;
      logic spi_req;
   } moc_irq_t;
   typedef struct packed {
      logic wdg_regs_en;
      logic reduced_wdg_clr_en;
      logic portd_ddr_en;
      logic spi_need_ddr;
      logic portd_open_drain_en;
      logic reset_pin_bidir;
      logic read_security;
      logic reduced_watchdog_enable;
      logic stop_instruction_disable;
      logic irq_level_sens;
   } moc_cfg_t;
endpackage

// ==== hdl/moc_wdg.sv ====
// Fixed-delay watchdog counter
`timescale 1ns/1ns
`default_nettype none
`include "moc_params.svh"
module moc_wdg
   import moc_pkg::*;
#(
   parameter int WDG_CYCLES = `MOC_WDG_CYCLES
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   // Control
   input wire logic enable_in,
   input wire logic restart_in,
   // Status
   output logic timeout_out
);
   logic [19:0] cnt_r;
   logic [19:0] cnt_nxt;
   logic timeout_nxt;
   wire logic expire = (cnt_r == 20'(WDG_CYCLES - 1));
   assign cnt_nxt = (!enable_in || restart_in || expire) ? 20'h0 : cnt_r + 20'h1;
   assign timeout_nxt = enable_in && !restart_in && expire;
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         cnt_r <= 20'h0;
         timeout_out <= 1'b0;
      end else if (ce_in) begin
         cnt_r <= cnt_nxt; // [R23]
         timeout_out <= timeout_nxt; // [R23]
      end
   end
endmodule
`default_nettype wire

// ==== hdl/moc_prio.sv ====
// Fixed priority interrupt selector and vector lookup
`timescale 1ns/1ns
`default_nettype none
`include "moc_params.svh"
module moc_prio
   import moc_pkg::*;
(
   // Requests
   input wire moc_irq_t req_in,
   input wire logic legacy_in,
   // Selection
   output logic any_out,
   output logic [15:0] vector_out
);
   logic [15:0] base;
   always_comb begin
      base = `MOC_VEC_SPI;
      if (req_in.reset_req) begin
         base = `MOC_VEC_RESET; // [R21]
      end else if (req_in.swi_req) begin
         base = `MOC_VEC_SWI;
      end else if (req_in.ext_req) begin
         base = `MOC_VEC_EXT;
      end else if (req_in.timer_req) begin
         base = `MOC_VEC_TIMER;
      end else if (req_in.sci_req) begin
         base = `MOC_VEC_SCI;
      end
   end
   assign any_out = |req_in;
   // Legacy vectors sit one 8K page lower
   assign vector_out = legacy_in ? (base & `MOC_VEC_LEG_MASK) : base; // [R22]
endmodule
`default_nettype wire

// ==== hdl/moc_top.sv ====
// Mode option configuration, memory map decode and interrupt entry
// Operation
// R01 - Mode comes from mode select option at reset: bit 6 legacy, bit 0 reduced.
// R02 - Watchdog registers on in full and legacy; reduced clear register only reduced.
// R03 - Port D direction register off in all modes; SPI needs direction only full.
// R04 - Port D open-drain control works only in full mode.
// R05 - Reset pin bidirectional in full mode, input only otherwise. Pin never driven: fixed watchdog is off in full mode.
// R06 - Reduced disables 0100-0FFF, legacy disables 2000-3FFF, full enables all.
// R07 - Legacy bit swaps pins, masks other bits, uses legacy option registers.
// R08 - Mode select bit 7 blocks external flash reads in every mode.
// R09 - Reduced mode only: bit 3 enables reduced watchdog.
// R10 - Reduced mode only: bit 2 disables stop instruction.
// R11 - Reduced mode only: bit 1 selects edge plus level irq.
// R12 - Memory irq option at 3FDF full, 1FDF legacy, absent in reduced.
// R13 - Option bit 7 maps RAM 0030-005F, reserves 0020-002F; clear maps program.
// R14 - Option bit 6 maps 96 RAM bytes from 0100; clear maps program.
// R15 - Option bit 3 read security in legacy only; cleared only by full erase.
// R16 - Option bit 1: falling edge plus low level, else falling edge only.
// R17 - Pull-up register at 3FF0 full/reduced, 1FF0 legacy; ones enable pull-ups.
// R18 - Writing 0 to watchdog clear bit restarts fixed watchdog; bit 0 kept.
// R19 - Legacy only: register at 1FF1, bit 0 enables fixed watchdog.
// R20 - Interrupt entry sets mask, stacks registers, fetches vector; return restores.
// R21 - Full/reduced vectors 3FFE..3FF4, served in fixed priority order.
// R22 - Legacy uses same priority with vectors 1FFE..1FF4.
// R23 - Enabled fixed watchdog forces reset 2**18 clocks after last restart.
// R24 - Mode captured once at reset and held until next reset.
`timescale 1ns/1ns
`default_nettype none
`include "moc_params.svh"
module moc_top
   import moc_pkg::*;
#(
   parameter int WDG_CYCLES = `MOC_WDG_CYCLES
) (
   // Clock, reset, enable
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   // Avalon-MM slave
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Core address decode
   input wire logic [15:0] cpu_addr_in,
   output logic mem_enabled_out,
   output logic ram_select_out,
   output logic reserved_out,
   // Interrupt requests and core handshake
   input wire moc_irq_t irq_req_in,
   input wire logic irq_ack_in,
   input wire logic rti_in,
   output logic irq_mask_out,
   output logic irq_take_out,
   output logic [15:0] vector_out,
   // Mode and configuration
   output moc_mode_t mode_out,
   output moc_cfg_t cfg_out,
   output logic [7:0] portb_pullup_out,
   output logic pin_swap_out,
   // Reset pin and fixed watchdog
   output logic reset_pin_o_out,
   output logic reset_pin_oe_b_out,
   output logic wdg_reset_out
);
   // ***************************************************
   // Option storage
   // ***************************************************
   logic [7:0] mode_sel_r;
   logic [7:0] mem_irq_r;
   logic [7:0] pullup_r;
   logic [7:0] wdg_en_r;
   logic captured_r;
   moc_mode_t mode_r;
   logic [7:0] mode_sel_nxt;
   logic [7:0] mem_irq_nxt;
   logic [7:0] pullup_nxt;
   logic [7:0] wdg_en_nxt;

   // ***************************************************
   // Bus decode
   // ***************************************************
   function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [7:0] new_v,
                                             input logic en);
      merge_byte = en ? new_v : old_v;
   endfunction

   wire logic legacy = (mode_r == MOC_LEGACY);
   wire logic reduced = (mode_r == MOC_REDUCED);
   wire logic full = (mode_r == MOC_FULL);
   wire logic wr = avs_write_in && !avs_waitrequest_out;
   wire logic rd = avs_read_in && !avs_waitrequest_out;
   wire logic be0 = avs_byteenable_in[0];
   wire logic [7:0] wbyte = avs_writedata_in[7:0];
   wire logic wr_mode = wr && be0 && (avs_address_in == `MOC_IDX_MODE_SEL);
   // Memory irq option does not exist in reduced mode
   wire logic wr_mem = wr && be0 && (avs_address_in == `MOC_IDX_MEM_IRQ) && !reduced; // [R12]
   wire logic wr_pull = wr && be0 && (avs_address_in == `MOC_IDX_PULLUP);
   wire logic wr_wdg = wr && be0 && (avs_address_in == `MOC_IDX_WDG_EN) && legacy; // [R19]
   // Clear strobe only in legacy and reduced; stored bit 0 untouched
   wire logic wdg_restart = wr_pull && !full && !wbyte[`MOC_WDG_CLR_BIT]; // [R18]

   assign mode_sel_nxt = merge_byte(mode_sel_r, wbyte, wr_mode);
   assign mem_irq_nxt = merge_byte(mem_irq_r, wbyte, wr_mem);
   // Bit 0 kept outside full mode; a zero there is only the restart strobe
   assign pullup_nxt = wr_pull ? (full ? wbyte : {wbyte[7:1], pullup_r[0]}) : pullup_r; // [R18]
   assign wdg_en_nxt = merge_byte(wdg_en_r, wbyte, wr_wdg);

   // ***************************************************
   // Mode capture
   // ***************************************************
   // Legacy bit wins and masks reduced selection
   wire moc_mode_t mode_dec = moc_mode_t'(mode_sel_r[`MOC_MS_LEGACY] ? MOC_LEGACY :
                              (mode_sel_r[`MOC_MS_REDUCED] ? MOC_REDUCED : MOC_FULL)); // [R01] [R07]

   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         // Option bytes model flash: kept through reset
         captured_r <= 1'b0;
         mode_r <= MOC_FULL;
      end else if (ce_in) begin
         if (!captured_r) begin
            captured_r <= 1'b1;
            mode_r <= mode_dec; // [R01] [R24]
         end
      end
   end

   // Option contents: software writes stand in for flash programming
   // Starts clear so only the first reset wipes the option bytes
   logic pwr_init_r = 1'b0;
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in && !pwr_init_r) begin
         pwr_init_r <= 1'b1;
         mode_sel_r <= `MOC_RST_BYTE;
         mem_irq_r <= `MOC_RST_BYTE;
         pullup_r <= `MOC_RST_BYTE;
         wdg_en_r <= `MOC_RST_BYTE;
      end else if (ce_in) begin
         mode_sel_r <= mode_sel_nxt;
         mem_irq_r <= mem_irq_nxt;
         pullup_r <= pullup_nxt; // [R17]
         wdg_en_r <= wdg_en_nxt; // [R19]
      end
   end

   // ***************************************************
   // Configuration decode
   // ***************************************************
   moc_cfg_t cfg_nxt;
   always_comb begin
      cfg_nxt.wdg_regs_en = !reduced; // [R02]
      cfg_nxt.reduced_wdg_clr_en = reduced; // [R02]
      cfg_nxt.portd_ddr_en = 1'b0; // [R03]
      cfg_nxt.spi_need_ddr = full; // [R03]
      cfg_nxt.portd_open_drain_en = full; // [R04]
      cfg_nxt.reset_pin_bidir = full; // [R05]
      cfg_nxt.read_security = mode_sel_r[`MOC_MS_SECURITY] ||
                              (legacy && mem_irq_r[`MOC_MI_SEC]); // [R08] [R15]
      cfg_nxt.reduced_watchdog_enable = reduced && mode_sel_r[`MOC_MS_RWDG]; // [R09]
      cfg_nxt.stop_instruction_disable = reduced && mode_sel_r[`MOC_MS_STOPDIS]; // [R10]
      cfg_nxt.irq_level_sens = reduced ? mode_sel_r[`MOC_MS_RIRQ] : mem_irq_r[`MOC_MI_IRQ]; // [R11] [R16]
   end

   // ***************************************************
   // Memory map
   // ***************************************************
   wire logic [15:0] a = cpu_addr_in;
   wire logic low_ram = mem_irq_r[`MOC_MI_LOW_RAM] && !reduced;
   wire logic page_ram = mem_irq_r[`MOC_MI_PAGE_RAM] && !reduced;
   wire logic in_red_gap = reduced && a >= `MOC_RED_LO && a <= `MOC_RED_HI; // [R06]
   wire logic in_leg_gap = legacy && a >= `MOC_LEG_LO && a <= `MOC_LEG_HI; // [R06]
   wire logic in_lram = low_ram && a >= `MOC_LRAM_LO && a <= `MOC_LRAM_HI; // [R13]
   wire logic in_lres = low_ram && a >= `MOC_LRES_LO && a <= `MOC_LRES_HI; // [R13]
   wire logic in_pram = page_ram && a >= `MOC_PRAM_LO &&
                        a < (`MOC_PRAM_LO + `MOC_PRAM_BYTES); // [R14]

   // ***************************************************
   // Interrupt entry
   // ***************************************************
   logic prio_any;
   logic [15:0] prio_vec;
   moc_prio u_prio (
      .req_in(irq_req_in),
      .legacy_in(legacy),
      .any_out(prio_any),
      .vector_out(prio_vec)
   );
   // Reset and software bypass the mask
   wire logic take = irq_ack_in && (irq_req_in.reset_req || irq_req_in.swi_req ||
                                    (prio_any && !irq_mask_out));

   // ***************************************************
   // Fixed watchdog
   // ***************************************************
   logic wdg_timeout;
   wire logic fixed_wdg_en = (legacy && wdg_en_r[`MOC_WDG_EN_BIT]) ||
                             cfg_nxt.reduced_watchdog_enable; // [R19]
   moc_wdg #(
      .WDG_CYCLES(WDG_CYCLES)
   ) u_wdg (
      .mclk_in(mclk_in),
      .rst_b_in(rst_b_in),
      .ce_in(ce_in),
      .enable_in(fixed_wdg_en),
      .restart_in(wdg_restart),
      .timeout_out(wdg_timeout)
   );

   // ***************************************************
   // Readback
   // ***************************************************
   wire logic [7:0] status_byte = {1'b0, wdg_timeout, irq_mask_out, mode_r, captured_r, legacy};
   logic [7:0] rbyte;
   always_comb begin
      unique case (avs_address_in)
         `MOC_IDX_MODE_SEL: rbyte = mode_sel_r;
         `MOC_IDX_MEM_IRQ: rbyte = reduced ? 8'h00 : mem_irq_r;
         `MOC_IDX_PULLUP: rbyte = pullup_r;
         `MOC_IDX_WDG_EN: rbyte = legacy ? wdg_en_r : 8'h00;
         `MOC_IDX_STATUS: rbyte = status_byte;
         `MOC_IDX_IRQ_REQ: rbyte = {2'h0, irq_req_in};
         `MOC_IDX_VECTOR: rbyte = prio_vec[7:0];
         `MOC_IDX_MAP_CHECK: rbyte = {4'h0, in_red_gap | in_leg_gap, in_lram, in_lres, in_pram};
         default: rbyte = 8'h00;
      endcase
   end

   // ***************************************************
   // Registered outputs
   // ***************************************************
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         avs_readdata_out <= 32'h0000_0000;
         avs_waitrequest_out <= 1'b1;
         mem_enabled_out <= 1'b0;
         ram_select_out <= 1'b0;
         reserved_out <= 1'b0;
         irq_mask_out <= 1'b1;
         irq_take_out <= 1'b0;
         vector_out <= 16'h0000;
         mode_out <= MOC_FULL;
         cfg_out <= '0;
         portb_pullup_out <= 8'h00;
         pin_swap_out <= 1'b0;
         reset_pin_o_out <= 1'b0;
         reset_pin_oe_b_out <= 1'b1;
         wdg_reset_out <= 1'b0;
      end else if (ce_in) begin
         // One wait cycle per access, then release
         avs_waitrequest_out <= !((avs_read_in || avs_write_in) && avs_waitrequest_out);
         if (avs_read_in && avs_waitrequest_out) begin
            avs_readdata_out <= {24'h0, rbyte};
         end
         mem_enabled_out <= !(in_red_gap || in_leg_gap); // [R06]
         ram_select_out <= in_lram || in_pram; // [R13] [R14]
         reserved_out <= in_lres; // [R13]
         irq_take_out <= take;
         if (take) begin
            irq_mask_out <= 1'b1; // [R20]
            vector_out <= prio_vec; // [R20] [R21] [R22]
         end else if (rti_in) begin
            irq_mask_out <= 1'b0; // [R20]
         end
         mode_out <= mode_r;
         cfg_out <= cfg_nxt;
         portb_pullup_out <= pullup_r; // [R17]
         pin_swap_out <= legacy; // [R07]
         wdg_reset_out <= wdg_timeout; // [R23]
         // Drive pin low only in full mode on watchdog reset
         reset_pin_o_out <= 1'b0;
         reset_pin_oe_b_out <= !(full && wdg_timeout); // [R05]
      end
   end
   wire logic unused_rd = rd;
endmodule
`default_nettype wire

// ==== tb/moc_monitor.sv ====
// Assertion checker for the mode option block
`timescale 1ns/1ns
`default_nettype none
module moc_monitor
   import moc_pkg::*;
#(
   parameter int WDG_CYCLES = 16
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_b_in,
   // Register bus
   input wire logic [3:0] avs_address_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic avs_waitrequest_out,
   // Interrupts
   input wire moc_irq_t irq_req_in,
   input wire logic irq_mask_out,
   input wire logic irq_take_out,
   input wire logic [15:0] vector_out,
   // Configuration
   input wire moc_mode_t mode_out,
   input wire moc_cfg_t cfg_out,
   input wire logic pin_swap_out,
   input wire logic reset_pin_oe_b_out,
   input wire logic wdg_reset_out
);
   // ************************
   // Helper counters
   // ************************
   logic [2:0] up_r;
   int wcnt_r;
   logic ok;
   logic full;
   logic red;
   logic restart;
   // Mode outputs settle two edges after release, so wait four
   assign ok = (up_r == 3'h4);
   assign full = (mode_out == MOC_FULL);
   assign red = (mode_out == MOC_REDUCED);
   assign restart = avs_write_in && !avs_waitrequest_out && (avs_address_in == 4'h2) && !avs_writedata_in[0];
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         up_r <= 3'h0;
         wcnt_r <= 0;
      end else begin
         up_r <= ok ? up_r : up_r + 3'h1;
         wcnt_r <= restart ? 0 : wcnt_r + 1;
      end
   end
   // ************************
   // Properties
   // ************************
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_b_in);
   property p_hold;
      ok && $past(ok) |-> $stable(mode_out);
   endproperty
   property p_wdg_regs;
      ok |-> (cfg_out.wdg_regs_en == !red) && (cfg_out.reduced_wdg_clr_en == red);
   endproperty
   property p_portd;
      ok |-> !cfg_out.portd_ddr_en && (cfg_out.spi_need_ddr == full);
   endproperty
   property p_odrain;
      ok |-> cfg_out.portd_open_drain_en == full;
   endproperty
   property p_rstpin;
      ok && !full |-> reset_pin_oe_b_out && !cfg_out.reset_pin_bidir;
   endproperty
   property p_swap;
      ok |-> pin_swap_out == (mode_out == MOC_LEGACY);
   endproperty
   property p_take;
      irq_take_out |-> irq_mask_out;
   endproperty
   property p_prio;
      irq_take_out && $past(irq_req_in.ext_req) && !$past(irq_req_in.reset_req) && !$past(irq_req_in.swi_req)
         |-> vector_out[12:0] == 13'h1FFA;
   endproperty
   // Slack of two covers the registered pulse
   property p_wdg;
      wdg_reset_out |-> (wcnt_r >= WDG_CYCLES - 2) && !full;
   endproperty
   a_hold: assert property (p_hold) else $error("mode changed without reset");
   a_wdg_regs: assert property (p_wdg_regs) else $error("watchdog register enables wrong");
   a_portd: assert property (p_portd) else $error("port D direction wrong");
   a_odrain: assert property (p_odrain) else $error("open drain enable wrong");
   a_rstpin: assert property (p_rstpin) else $error("reset pin driven outside full mode");
   a_swap: assert property (p_swap) else $error("pin swap wrong");
   a_take: assert property (p_take) else $error("mask not set on entry");
   a_prio: assert property (p_prio) else $error("external vector wrong");
   a_wdg: assert property (p_wdg) else $error("watchdog fired early");
   c_leg: cover property (irq_take_out && mode_out == MOC_LEGACY);
   c_wdg: cover property (wdg_reset_out);
   c_red: cover property (ok && red);
endmodule
`default_nettype wire

// ==== tb/moc_core_model.sv ====
// Core stand-in: returns, raises requests, waits for entry
`timescale 1ns/1ns
`default_nettype none
module moc_core_model
   import moc_pkg::*;
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_b_in,
   // Bench control
   input wire logic start_in,
   input wire logic [5:0] pattern_in,
   output logic busy_out,
   // Block side
   input wire logic irq_take_in,
   output moc_irq_t irq_req_out,
   output logic irq_ack_out,
   output logic rti_out
);
   logic [2:0] st_r;
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         st_r <= 3'h0;
         busy_out <= 1'b0;
         irq_req_out <= '0;
         irq_ack_out <= 1'b0;
         rti_out <= 1'b0;
      end else begin
         case (st_r)
            3'h0: begin
               busy_out <= start_in;
               rti_out <= start_in; // Return first so the mask is clear
               st_r <= start_in ? 3'h1 : 3'h0;
            end
            3'h1: begin
               rti_out <= 1'b0;
               st_r <= 3'h2;
            end
            3'h2: begin
               irq_req_out <= pattern_in;
               irq_ack_out <= 1'b1;
               st_r <= 3'h3;
            end
            3'h3: begin
               // One cycle only, else reset and software enter twice
               irq_req_out <= '0;
               irq_ack_out <= 1'b0;
               st_r <= 3'h4;
            end
            default: begin
               busy_out <= !irq_take_in;
               st_r <= irq_take_in ? 3'h0 : 3'h4;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== tb/moc_top_tb.sv ====
// Self-checking bench for the mode option block
`timescale 1ns/1ns
`default_nettype none
module moc_top_tb;
   import moc_pkg::*;
   localparam int WDGC = 16;
   localparam logic [7:0] OPT = 8'hCA;
   logic clk, rst_b, ce, rd, wr, wreq, ack, return_from_interrupt, mask, take, swap, rpo, rpoe_b, wdg, men, ram, res, start, busy;
   logic [3:0] adr, be;
   logic [31:0] wd, rdat;
   logic [15:0] caddr, vec, a;
   logic [7:0] pu, m, d;
   logic [5:0] pat;
   logic l, r;
   moc_irq_t req;
   moc_mode_t mode;
   moc_cfg_t cfg;
   int fails = 0, num_checks = 0, cyc = 0, wdg_seen = 0, seed, w0;
   logic [15:0] vec_q [$];
   logic [7:0] rd_q [$];
   logic [15:0] atab [13] = '{16'h0020, 16'h002F, 16'h0030, 16'h005F, 16'h0060, 16'h0100, 16'h015F,
      16'h0160, 16'h0FFF, 16'h1000, 16'h1FFF, 16'h2000, 16'h3FFF};
   logic [7:0] mtab [4] = '{8'h8E, 8'h07, 8'h09, 8'h4F};
   moc_top #(.WDG_CYCLES(WDGC)) i_moc_top (.mclk_in(clk), .rst_b_in(rst_b), .ce_in(ce), .avs_address_in(adr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdat),
      .avs_waitrequest_out(wreq), .cpu_addr_in(caddr), .mem_enabled_out(men), .ram_select_out(ram),
      .reserved_out(res), .irq_req_in(req), .irq_ack_in(ack), .rti_in(return_from_interrupt), .irq_mask_out(mask),
      .irq_take_out(take), .vector_out(vec), .mode_out(mode), .cfg_out(cfg), .portb_pullup_out(pu),
      .pin_swap_out(swap), .reset_pin_o_out(rpo), .reset_pin_oe_b_out(rpoe_b), .wdg_reset_out(wdg));
   moc_core_model i_moc_core_model (.mclk_in(clk), .rst_b_in(rst_b), .start_in(start), .pattern_in(pat),
      .busy_out(busy), .irq_take_in(take), .irq_req_out(req), .irq_ack_out(ack), .rti_out(return_from_interrupt));
   // ************************
   // Tasks
   // ************************
   task automatic results;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string s);
      num_checks++;
      if (ok !== 1'b1) begin
         fails++;
         $display("BAD %0t %s", $time, s);
      end
   endtask
   // Idle cycle after each access keeps strobes from being driven twice at one edge
   task automatic bus(input logic w, input logic [3:0] x, input logic [7:0] v);
      adr <= x;
      wr <= w;
      rd <= !w;
      wd <= {24'h0, v};
      @(posedge clk);
      while (wreq !== 1'b0) @(posedge clk);
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdc(input logic [3:0] x, input logic [7:0] e);
      rd_q.push_back(e);
      bus(1'b0, x, 8'h00);
   endtask
   task automatic irq(input logic [5:0] p, input logic [15:0] v);
      vec_q.push_back(v);
      pat <= p;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      @(posedge clk);
      while (busy !== 1'b0) @(posedge clk);
   endtask
   task automatic do_reset;
      rst_b <= 1'b0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge clk);
   endtask
   // ************************
   // Clock, watcher, sequence
   // ************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (wdg === 1'b1) wdg_seen <= wdg_seen + 1;
      if (take === 1'b1) chk(vec === vec_q.pop_front(), "vector");
      if (rd === 1'b1 && wreq === 1'b0) chk(rdat[7:0] === rd_q.pop_front(), "read data");
      if (cyc == 20000) begin
         fails++;
         results();
      end
   end
   initial begin
      {rst_b, rd, wr, start} = 4'h0;
      {adr, wd, caddr, pat} = '0;
      ce = 1'b1;
      be = 4'h1;
      seed = 32'h16E9;
      do_reset();
      bus(1'b1, 4'h1, OPT);
      bus(1'b1, 4'h3, 8'h01);
      rdc(4'h3, 8'h00);
      rdc(4'h1, OPT);
      bus(1'b1, 4'h9, 8'h5A);
      rdc(4'h9, 8'h00);
      repeat (4) begin
         d = 8'($random(seed));
         bus(1'b1, 4'h2, d);
         rdc(4'h2, d);
         chk(pu === d, "pull-ups");
      end
      foreach (mtab[k]) begin
         m = mtab[k];
         l = m[6];
         r = !m[6] && m[0];
         bus(1'b1, 4'h0, m);
         do_reset();
         chk(mode === (l ? MOC_LEGACY : (r ? MOC_REDUCED : MOC_FULL)), "mode");
         chk(cfg === moc_cfg_t'({!r, r, 1'b0, !l && !r, !l && !r, !l && !r, m[7] || (l && OPT[3]), r && m[3],
            r && m[2], r ? m[1] : OPT[1]}), "config");
         chk(swap === l, "swap");
         if (r) bus(1'b1, 4'h1, 8'h00);
         for (int i = 0; i < 17; i++) begin
            a = (i < 13) ? atab[i] : (16'($random(seed)) & 16'h3FFF);
            caddr <= a;
            repeat (2) @(posedge clk);
            chk(men === !((r && a >= 16'h0100 && a <= 16'h0FFF) || (l && a >= 16'h2000)), "enable");
            if (!r) chk({ram, res} === {(OPT[7] && a >= 16'h0030 && a <= 16'h005F) || (OPT[6] && a >= 16'h0100
               && a <= 16'h015F), OPT[7] && a >= 16'h0020 && a <= 16'h002F}, "map");
         end
         for (int i = 0; i < 6; i++) irq(6'h3F >> i, (16'h3FFE - 16'(2 * i)) & (l ? 16'h1FFF : 16'hFFFF));
      end
      rdc(4'h1, OPT);
      bus(1'b1, 4'h0, 8'h00);
      repeat (3) @(posedge clk);
      chk(mode === MOC_LEGACY, "mode held");
      chk(mask === 1'b1, "mask left set");
      chk(rpo === 1'b0 && rpoe_b === 1'b1, "reset pin input only");
      rdc(4'h4, 8'h33);
      bus(1'b1, 4'h2, 8'hA5);
      bus(1'b1, 4'h2, 8'h3C);
      rdc(4'h2, {7'h1E, d[0]});
      chk(pu === {7'h1E, d[0]}, "pull-up bit 0 kept");
      bus(1'b1, 4'h3, 8'h01);
      w0 = wdg_seen;
      repeat (8) begin
         bus(1'b1, 4'h2, 8'h00);
         repeat (5) @(posedge clk);
      end
      chk(wdg_seen === w0, "watchdog restart");
      repeat (3 * WDGC) @(posedge clk);
      chk(wdg_seen > w0, "watchdog expiry");
      results();
   end
endmodule
bind moc_top moc_monitor #(.WDG_CYCLES(WDG_CYCLES)) i_moc_monitor (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
   .avs_address_in(avs_address_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
   .avs_waitrequest_out(avs_waitrequest_out), .irq_req_in(irq_req_in), .irq_mask_out(irq_mask_out),
   .irq_take_out(irq_take_out), .vector_out(vector_out), .mode_out(mode_out), .cfg_out(cfg_out),
   .pin_swap_out(pin_swap_out), .reset_pin_oe_b_out(reset_pin_oe_b_out), .wdg_reset_out(wdg_reset_out));
`default_nettype wire
